/* File: hdl/vsrsu_cfg.svh */
// Constants of the vector shift-right and subtract unit
// Operation
// RL1: Arithmetic byte right shift by low three count bits, sign fill.
// RL2: Arithmetic halfword right shift by low four count bits, sign fill.
// RL3: Arithmetic word right shift by low five count bits, sign fill.
// RL4: Logical byte right shift by low three count bits, zero fill.
// RL5: Logical halfword right shift by low four count bits, zero fill.
// RL6: Logical word right shift by low five count bits, zero fill.
// RL7: Whole register right shift by bytes from source_b bits 121-124.
// RL8: Unsigned word subtract writes inverted borrow, zero extended, per element.
// RL9: Single precision subtract per word, rounded to nearest even.
// RL10: Flush mode zeroes denormal inputs and results, keeping sign.
// RL11: Signed byte subtract clamps to -128..127, sets saturation flag.
// RL12: Signed halfword subtract clamps to 16-bit range, sets saturation flag.
// RL13: Software may build a 0-127 bit funnel shift from six operations.
// RL14: Signed word subtract clamps to 32-bit range, sets saturation flag.
// RL15: Whole register right shift by source_b bits 125-127, zero fill.
// RL16: Decode primary opcode 4 plus eleven bit extended opcode.
// RL17: Saturation flag sticky, cleared only by explicit write.
// RL18: Full 128-bit result written once after both sources read.
`ifndef VSRSU_CFG_SVH
`define VSRSU_CFG_SVH

`define VSRSU_PRIM_OP 6'h04
`define VSRSU_PRIM_MSB 31
`define VSRSU_PRIM_LSB 26
`define VSRSU_XO_MSB 10
`define VSRSU_XO_LSB 0
`define VSRSU_DST_MSB 25
`define VSRSU_DST_LSB 21

`define VSRSU_XO_SRAB 11'h304
`define VSRSU_XO_SRAH 11'h344
`define VSRSU_XO_SRAW 11'h384
`define VSRSU_XO_SRB 11'h204
`define VSRSU_XO_SRH 11'h244
`define VSRSU_XO_SRW 11'h284
`define VSRSU_XO_SRO 11'h44c
`define VSRSU_XO_SR 11'h2c4
`define VSRSU_XO_SUBCUW 11'h580
`define VSRSU_XO_SUBFP 11'h04a
`define VSRSU_XO_SUBSBS 11'h700
`define VSRSU_XO_SUBSHS 11'h740
`define VSRSU_XO_SUBSWS 11'h780

// Octet count is bits 121-124, bit count 125-127 (bit 0 is the MSB)
`define VSRSU_OCT_MSB 6
`define VSRSU_OCT_LSB 3
`define VSRSU_BIT_MSB 2
`define VSRSU_BIT_LSB 0

`define VSRSU_SAT_RST 1'b0
`define VSRSU_QNAN 32'h7fc0_0000
`define VSRSU_EXP_MAX 8'hff

`endif

/* File: hdl/vsrsu_fp_lane.sv */
// One single precision subtract lane, round to nearest even
`timescale 1ns/100ps
`include "vsrsu_cfg.svh"
module vsrsu_fp_lane
	import vsrsu_pkg::*;
(
	input wire logic [31:0] op_a,
	input wire logic [31:0] op_b,
	input wire logic flush,
	output logic [31:0] diff
);

	function automatic logic [4:0] vsrsu_lzc(input logic [26:0] v);
		logic [4:0] n;
		logic f;
		n = 5'h0;
		f = 1'b0;
		for (int i = 26; i >= 0; i--) begin
			if (!f) begin
				if (v[i]) f = 1'b1;
				else n = n + 5'h1;
			end
		end
		return n;
	endfunction : vsrsu_lzc

	wire sa = op_a[31];
	wire sb = ~op_b[31];
	wire [7:0] ea = op_a[30:23];
	wire [7:0] eb = op_b[30:23];
	// Flushed denormal inputs become signed zero
	wire [22:0] fa = (flush && ea == 8'h0) ? 23'h0 : op_a[22:0]; // RL10
	wire [22:0] fb = (flush && eb == 8'h0) ? 23'h0 : op_b[22:0]; // RL10
	wire nan_a = ea == `VSRSU_EXP_MAX && fa != 23'h0;
	wire nan_b = eb == `VSRSU_EXP_MAX && fb != 23'h0;
	wire inf_a = ea == `VSRSU_EXP_MAX && fa == 23'h0;
	wire inf_b = eb == `VSRSU_EXP_MAX && fb == 23'h0;
	wire eff_sub = sa ^ sb;

	wire a_big = {ea, fa} >= {eb, fb};
	wire sx = a_big ? sa : sb;
	wire [7:0] ex = a_big ? ea : eb;
	wire [7:0] ey = a_big ? eb : ea;
	wire [22:0] fx = a_big ? fa : fb;
	wire [22:0] fy = a_big ? fb : fa;
	wire [7:0] ex_u = (ex == 8'h0) ? 8'h1 : ex;
	wire [7:0] ey_u = (ey == 8'h0) ? 8'h1 : ey;
	wire [26:0] mx = {ex != 8'h0, fx, 3'h0};
	wire [23:0] my = {ey != 8'h0, fy};
	wire [7:0] dexp = ex_u - ey_u;
	// Beyond 31 places the smaller operand is all sticky anyway
	wire [4:0] dsh = (dexp > 8'd31) ? 5'd31 : dexp[4:0];
	wire [58:0] yw = {my, 35'h0} >> dsh;
	wire [26:0] my_al = {yw[58:33], |yw[32:0]};

	wire [27:0] sum = eff_sub ? ({1'b0, mx} - {1'b0, my_al}) : ({1'b0, mx} + {1'b0, my_al});
	wire [4:0] lz = vsrsu_lzc(sum[26:0]);
	wire [7:0] lim = ex_u - 8'h1;
	wire [4:0] shl = ({3'h0, lz} > lim) ? lim[4:0] : lz;
	wire [26:0] norm = sum[27] ? {sum[27:2], sum[1] | sum[0]} : (sum[26:0] << shl);
	wire [9:0] en = sum[27] ? ({2'h0, ex_u} + 10'h1) : ({2'h0, ex_u} - {5'h0, shl});

	// Nearest even: guard set and any of round, sticky or lsb
	wire inc = norm[2] & (norm[1] | norm[0] | norm[3]); // RL9
	wire [24:0] rnd = {1'b0, norm[26:3]} + {24'h0, inc}; // RL9
	wire [23:0] man = rnd[24] ? rnd[24:1] : rnd[23:0];
	wire [9:0] er = rnd[24] ? en + 10'h1 : en;
	wire ovf = er >= {2'h0, `VSRSU_EXP_MAX};
	wire [7:0] ef = man[23] ? er[7:0] : 8'h0;
	wire den_r = !man[23] && man != 24'h0;
	wire zsign = eff_sub ? 1'b0 : sx;

	wire [31:0] qnan = `VSRSU_QNAN;
	wire [31:0] fin =
		(sum == 28'h0) ? {zsign, 31'h0} :
		ovf ? {sx, `VSRSU_EXP_MAX, 23'h0} :
		(flush && den_r) ? {sx, 31'h0} : // RL10
		{sx, ef, man[22:0]};

	assign diff = (nan_a || nan_b || (inf_a && inf_b && eff_sub)) ? qnan :
		inf_a ? {sa, `VSRSU_EXP_MAX, 23'h0} :
		inf_b ? {sb, `VSRSU_EXP_MAX, 23'h0} :
		fin;

endmodule : vsrsu_fp_lane

/* File: hdl/vsrsu_pkg.sv */
// Types of the vector shift-right and subtract unit
package vsrsu_pkg;

	typedef enum logic [3:0] {
		VSRSU_OP_NONE = 4'b0000,
		VSRSU_OP_SRAB = 4'b0001,
		VSRSU_OP_SRAH = 4'b0010,
		VSRSU_OP_SRAW = 4'b0011,
		VSRSU_OP_SRB = 4'b0100,
		VSRSU_OP_SRH = 4'b0101,
		VSRSU_OP_SRW = 4'b0110,
		VSRSU_OP_SRO = 4'b0111,
		VSRSU_OP_SR = 4'b1000,
		VSRSU_OP_SUBCUW = 4'b1001,
		VSRSU_OP_SUBFP = 4'b1010,
		VSRSU_OP_SUBSBS = 4'b1011,
		VSRSU_OP_SUBSHS = 4'b1100,
		VSRSU_OP_SUBSWS = 4'b1101
	} vsrsu_op_t;

	typedef struct packed {
		logic [31:0] instr;
		logic [127:0] source_a;
		logic [127:0] source_b;
	} vsrsu_req_t;

	typedef struct packed {
		logic valid;
		logic [4:0] destination;
		logic [127:0] data;
	} vsrsu_res_t;

endpackage : vsrsu_pkg

/* File: hdl/vsrsu_top.sv */
// Vector shift-right and subtract datapath, one issue per cycle
`timescale 1ns/100ps
`include "vsrsu_cfg.svh"
module vsrsu_top
	import vsrsu_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic issue_valid,
	input wire vsrsu_req_t issue,
	input wire logic denormal_flush_mode,
	input wire logic sat_wr_en,
	input wire logic sat_wr_val,
	output vsrsu_res_t result,
	output logic saturation_flag,
	output logic bad_opcode
);

	////////////////////////////////////////////////////////////////////////
	// Decode

	function automatic vsrsu_op_t vsrsu_decode(input logic [31:0] ins);
		vsrsu_op_t op;
		op = VSRSU_OP_NONE;
		if (ins[`VSRSU_PRIM_MSB:`VSRSU_PRIM_LSB] == `VSRSU_PRIM_OP) begin // RL16
			case (ins[`VSRSU_XO_MSB:`VSRSU_XO_LSB]) // RL16
				`VSRSU_XO_SRAB: op = VSRSU_OP_SRAB;
				`VSRSU_XO_SRAH: op = VSRSU_OP_SRAH;
				`VSRSU_XO_SRAW: op = VSRSU_OP_SRAW;
				`VSRSU_XO_SRB: op = VSRSU_OP_SRB;
				`VSRSU_XO_SRH: op = VSRSU_OP_SRH;
				`VSRSU_XO_SRW: op = VSRSU_OP_SRW;
				`VSRSU_XO_SRO: op = VSRSU_OP_SRO;
				`VSRSU_XO_SR: op = VSRSU_OP_SR;
				`VSRSU_XO_SUBCUW: op = VSRSU_OP_SUBCUW;
				`VSRSU_XO_SUBFP: op = VSRSU_OP_SUBFP;
				`VSRSU_XO_SUBSBS: op = VSRSU_OP_SUBSBS;
				`VSRSU_XO_SUBSHS: op = VSRSU_OP_SUBSHS;
				`VSRSU_XO_SUBSWS: op = VSRSU_OP_SUBSWS;
				default: op = VSRSU_OP_NONE;
			endcase
		end
		return op;
	endfunction : vsrsu_decode

	wire vsrsu_op_t op_d = vsrsu_decode(issue.instr);
	wire [127:0] sa = issue.source_a;
	wire [127:0] sb = issue.source_b;

	////////////////////////////////////////////////////////////////////////
	// Element lanes

	logic [127:0] srab_r, srb_r, subsb_r;
	logic [127:0] srah_r, srh_r, subsh_r;
	logic [127:0] sraw_r, srw_r, subsw_r, subc_r, fp_r;
	logic [15:0] clamp_b;
	logic [7:0] clamp_h;
	logic [3:0] clamp_w;

	for (genvar i = 0; i < 16; i++) begin : g_byte
		wire [7:0] a = sa[8*i +: 8];
		wire [7:0] b = sb[8*i +: 8];
		wire [2:0] sh = b[2:0];
		wire [8:0] df = {a[7], a} - {b[7], b};
		assign srab_r[8*i +: 8] = $signed(a) >>> sh; // RL1
		assign srb_r[8*i +: 8] = a >> sh; // RL4
		// Overflow shows as the two top bits of the wide difference disagreeing
		assign clamp_b[i] = df[8] ^ df[7]; // RL11
		assign subsb_r[8*i +: 8] = clamp_b[i] ? {df[8], {7{~df[8]}}} : df[7:0]; // RL11
	end

	for (genvar i = 0; i < 8; i++) begin : g_half
		wire [15:0] a = sa[16*i +: 16];
		wire [15:0] b = sb[16*i +: 16];
		wire [3:0] sh = b[3:0];
		wire [16:0] df = {a[15], a} - {b[15], b};
		assign srah_r[16*i +: 16] = $signed(a) >>> sh; // RL2
		assign srh_r[16*i +: 16] = a >> sh; // RL5
		assign clamp_h[i] = df[16] ^ df[15]; // RL12
		assign subsh_r[16*i +: 16] = clamp_h[i] ? {df[16], {15{~df[16]}}} : df[15:0]; // RL12
	end

	for (genvar i = 0; i < 4; i++) begin : g_word
		wire [31:0] a = sa[32*i +: 32];
		wire [31:0] b = sb[32*i +: 32];
		wire [4:0] sh = b[4:0];
		wire [32:0] df = {a[31], a} - {b[31], b};
		wire [32:0] du = {1'b0, a} - {1'b0, b};
		assign sraw_r[32*i +: 32] = $signed(a) >>> sh; // RL3
		assign srw_r[32*i +: 32] = a >> sh; // RL6
		assign clamp_w[i] = df[32] ^ df[31]; // RL14
		assign subsw_r[32*i +: 32] = clamp_w[i] ? {df[32], {31{~df[32]}}} : df[31:0]; // RL14
		// No borrow out of the top bit gives a one
		assign subc_r[32*i +: 32] = {31'h0, ~du[32]}; // RL8
		vsrsu_fp_lane u_fp (
			.op_a(a),
			.op_b(b),
			.flush(denormal_flush_mode),
			.diff(fp_r[32*i +: 32])
		); // RL9 RL10
	end

	// Byte and bit counts come from the last byte; other bytes of the count are ignored
	wire [6:0] oct_sh = {sb[`VSRSU_OCT_MSB:`VSRSU_OCT_LSB], 3'h0};
	wire [127:0] sro_r = sa >> oct_sh; // RL7
	wire [127:0] sr_r = sa >> sb[`VSRSU_BIT_MSB:`VSRSU_BIT_LSB]; // RL15

	////////////////////////////////////////////////////////////////////////
	// Result selection

	wire [127:0] data_d =
		(op_d == VSRSU_OP_SRAB) ? srab_r :
		(op_d == VSRSU_OP_SRAH) ? srah_r :
		(op_d == VSRSU_OP_SRAW) ? sraw_r :
		(op_d == VSRSU_OP_SRB) ? srb_r :
		(op_d == VSRSU_OP_SRH) ? srh_r :
		(op_d == VSRSU_OP_SRW) ? srw_r :
		(op_d == VSRSU_OP_SRO) ? sro_r :
		(op_d == VSRSU_OP_SR) ? sr_r :
		(op_d == VSRSU_OP_SUBCUW) ? subc_r :
		(op_d == VSRSU_OP_SUBFP) ? fp_r :
		(op_d == VSRSU_OP_SUBSBS) ? subsb_r :
		(op_d == VSRSU_OP_SUBSHS) ? subsh_r :
		(op_d == VSRSU_OP_SUBSWS) ? subsw_r :
		128'h0;

	wire legal = op_d != VSRSU_OP_NONE;
	wire sat_set = issue_valid && (
		(op_d == VSRSU_OP_SUBSBS && |clamp_b) || // RL11
		(op_d == VSRSU_OP_SUBSHS && |clamp_h) || // RL12
		(op_d == VSRSU_OP_SUBSWS && |clamp_w)); // RL14
	// Set beats a same-cycle software clear
	wire sat_d = sat_set | (sat_wr_en ? sat_wr_val : saturation_flag); // RL17

	vsrsu_res_t res_d;
	assign res_d.valid = issue_valid && legal; // RL18
	assign res_d.destination = issue.instr[`VSRSU_DST_MSB:`VSRSU_DST_LSB];
	assign res_d.data = data_d; // RL18

	////////////////////////////////////////////////////////////////////////
	// Registers

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			result <= '0;
			saturation_flag <= `VSRSU_SAT_RST;
			bad_opcode <= 1'b0;
		end else begin
			result <= res_d; // RL18
			saturation_flag <= sat_d; // RL17
			bad_opcode <= issue_valid && !legal; // RL16
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	a_srab_lane: assert property (issue_valid && op_d == VSRSU_OP_SRAB |=> // RL1
		result.data[127:120] == 8'($signed($past(sa[127:120])) >>> $past(sb[122:120])))
		else $error("byte arithmetic shift wrong");
	a_srah_sign: assert property (issue_valid && op_d == VSRSU_OP_SRAH && sa[15] && sb[3:0] == 4'hf |=> // RL2
		result.data[15:0] == 16'hffff)
		else $error("halfword sign fill wrong");
	a_sraw_lane: assert property (issue_valid && op_d == VSRSU_OP_SRAW |=> // RL3
		result.data[31:0] == 32'($signed($past(sa[31:0])) >>> $past(sb[4:0])))
		else $error("word arithmetic shift wrong");
	a_srb_zero: assert property (issue_valid && op_d == VSRSU_OP_SRB && sb[2:0] != 3'h0 |=> // RL4
		result.data[7] == 1'b0)
		else $error("byte logical shift not zero filled");
	a_srh_lane: assert property (issue_valid && op_d == VSRSU_OP_SRH |=> // RL5
		result.data[31:16] == ($past(sa[31:16]) >> $past(sb[19:16])))
		else $error("halfword logical shift wrong");
	a_srw_lane: assert property (issue_valid && op_d == VSRSU_OP_SRW |=> // RL6
		result.data[127:96] == ($past(sa[127:96]) >> $past(sb[100:96])))
		else $error("word logical shift wrong");
	a_octet_shift: assert property (issue_valid && op_d == VSRSU_OP_SRO |=> // RL7
		result.data == ($past(sa) >> {$past(sb[6:3]), 3'h0}))
		else $error("octet shift wrong");
	a_bit_shift: assert property (issue_valid && op_d == VSRSU_OP_SR |=> // RL15
		result.data == ($past(sa) >> $past(sb[2:0])))
		else $error("register bit shift wrong");
	a_carry_out: assert property (issue_valid && op_d == VSRSU_OP_SUBCUW |=> // RL8
		result.data[63:32] == {31'h0, $past(sa[63:32]) >= $past(sb[63:32])})
		else $error("carry out wrong");
	a_fp_self: assert property (issue_valid && op_d == VSRSU_OP_SUBFP && sa[31:0] == sb[31:0] // RL9
		&& sa[30:23] != `VSRSU_EXP_MAX |=> result.data[31:0] == 32'h0)
		else $error("x minus x not plus zero");
	a_fp_flush: assert property (issue_valid && op_d == VSRSU_OP_SUBFP && denormal_flush_mode // RL10
		&& sa[30:23] == 8'h0 && sb[30:23] == 8'h0 |=> result.data[30:0] == 31'h0)
		else $error("denormal not flushed");
	a_satb_clamp: assert property (issue_valid && op_d == VSRSU_OP_SUBSBS && sa[7:0] == 8'h7f // RL11
		&& sb[7:0] == 8'hff |=> result.data[7:0] == 8'h7f && saturation_flag)
		else $error("byte clamp wrong");
	a_sath_clamp: assert property (issue_valid && op_d == VSRSU_OP_SUBSHS && sa[15:0] == 16'h8000 // RL12
		&& sb[15:0] == 16'h0001 |=> result.data[15:0] == 16'h8000 && saturation_flag)
		else $error("halfword clamp wrong");
	a_satw_clamp: assert property (issue_valid && op_d == VSRSU_OP_SUBSWS && clamp_w[0] |=> // RL14
		result.data[31:0] == ($past(sa[31]) ? 32'h8000_0000 : 32'h7fff_ffff) && saturation_flag)
		else $error("word clamp wrong");
	a_sat_sticky: assert property (saturation_flag && !sat_wr_en |=> saturation_flag) // RL17
		else $error("saturation flag dropped without write");
	a_sat_hold: assert property (!saturation_flag && !sat_wr_en && !(issue_valid && (op_d == VSRSU_OP_SUBSBS
		|| op_d == VSRSU_OP_SUBSHS || op_d == VSRSU_OP_SUBSWS)) |=> !saturation_flag) // RL17
		else $error("saturation flag set by other operation");
	a_bad_nowrite: assert property (issue_valid && !legal |=> bad_opcode && !result.valid) // RL16
		else $error("illegal opcode wrote a result");
	a_one_write: assert property (issue_valid && legal |=> result.valid ##1 !result.valid || $past(issue_valid)) // RL18
		else $error("result not written exactly once");
	a_dest_field: assert property (issue_valid && legal |=> result.destination == $past(issue.instr[25:21])) // RL18
		else $error("destination field wrong");

	c_sat_event: cover property (issue_valid && sat_set ##1 saturation_flag);
	c_fp_issue: cover property (issue_valid && op_d == VSRSU_OP_SUBFP ##1 result.valid);
	c_set_clear: cover property (sat_set && sat_wr_en && !sat_wr_val);
	c_back2back: cover property (issue_valid && legal ##1 issue_valid && legal);

endmodule : vsrsu_top

/* File: sim/tb_top.sv */
// Self-checking bench for the vector shift-right and subtract datapath
`timescale 1ns/100ps
module tb_top
	import vsrsu_pkg::*;
;
	localparam logic [127:0] SA = 128'h8123_4567_89ab_cdef_f0e1_d2c3_b4a5_9687;
	localparam logic [127:0] SB = 128'h0011_2233_4455_6677_8899_aabb_ccdd_eeff;
	localparam logic [127:0] SN = {8{16'h1234}};
	localparam logic [127:0] SM = {8{16'h0101}};
	localparam logic [127:0] SC = {8{16'h7f80}};
	localparam logic [127:0] SD = {8{16'hff01}};
	localparam logic [127:0] SUA = {32'h0000_0000, 32'hffff_ffff, 32'h0000_0001, 32'h8000_0000};
	localparam logic [127:0] SUB = {32'h0000_0000, 32'h0000_0000, 32'h0000_0002, 32'h8000_0001};
	localparam logic [127:0] SUX = {32'h0000_0001, 32'h0000_0001, 32'h0000_0000, 32'h0000_0000};
	localparam logic [127:0] FA = {32'h3f80_0000, 32'h0000_0001, 32'h0080_0001, 32'h8000_0001};
	localparam logic [127:0] FB = {32'h3300_0000, 32'h0000_0000, 32'h0080_0000, 32'h0000_0000};
	localparam logic [127:0] FN = {32'h3f80_0000, 32'h0000_0001, 32'h0000_0001, 32'h8000_0001};
	localparam logic [127:0] FF = {32'h3f80_0000, 32'h0000_0000, 32'h0000_0000, 32'h8000_0000};

	logic mclk;
	logic rst_n;
	logic issue_valid;
	vsrsu_req_t issue;
	logic denormal_flush_mode;
	logic sat_wr_en;
	logic sat_wr_val;
	vsrsu_res_t result;
	logic saturation_flag;
	logic bad_opcode;
	int fails;
	int n_checks;

	vsrsu_top dut (.mclk(mclk), .rst_n(rst_n), .issue_valid(issue_valid), .issue(issue),
		.denormal_flush_mode(denormal_flush_mode), .sat_wr_en(sat_wr_en), .sat_wr_val(sat_wr_val),
		.result(result), .saturation_flag(saturation_flag), .bad_opcode(bad_opcode));
	vsrsu_disp_model disp (.mclk(mclk), .rst_n(rst_n), .result(result), .issue_valid(issue_valid), .issue(issue));

	always #2.5 mclk = ~mclk;

	////////////////////////////////////////////////////////////////////////
	// Reference arithmetic
	function automatic logic [31:0] ins(input logic [10:0] xo, input logic [4:0] d);
		// Source register fields are nonzero on purpose: they must be ignored
		return {6'h04, d, 5'h0a, 5'h15, xo};
	endfunction : ins

	function automatic logic [127:0] shr(input logic [127:0] a, input logic [127:0] b, input int w, input bit ar);
		logic [31:0] m;
		logic [31:0] e;
		logic [31:0] r;
		int n;
		shr = '0;
		m = 32'hffff_ffff >> (32 - w);
		for (int i = 0; i < 128; i += w) begin
			e = 32'(a >> i) & m;
			n = int'(32'(b >> i) & 32'(w - 1));
			r = e >> n;
			if (ar && e[w - 1]) r = r | (~(m >> n) & m);
			shr = shr | (128'(r) << i);
		end
	endfunction : shr

	function automatic longint sx(input logic [127:0] v, input int w);
		longint t;
		t = longint'(64'(v) & ((64'd1 << w) - 64'd1));
		if (t >= (longint'(1) << (w - 1))) t = t - (longint'(1) << w);
		return t;
	endfunction : sx

	function automatic logic [127:0] sats(input logic [127:0] a, input logic [127:0] b, input int w);
		longint x;
		longint hi;
		sats = '0;
		hi = (longint'(1) << (w - 1)) - 1;
		for (int i = 0; i < 128; i += w) begin
			x = sx(a >> i, w) - sx(b >> i, w);
			if (x > hi) x = hi;
			if (x < -hi - 1) x = -hi - 1;
			sats = sats | ((128'(x) & ((128'd1 << w) - 128'd1)) << i);
		end
	endfunction : sats

	////////////////////////////////////////////////////////////////////////
	// Checking and closing
	task chk(input logic [159:0] seen, input logic [159:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	task tally_and_finish;
		if (fails == 0 && n_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : tally_and_finish

	// One issue, result judged in the following cycle
	task go(input logic [31:0] i, input logic [127:0] a, input logic [127:0] b, input logic [127:0] exp);
		@(posedge mclk);
		disp.put(i, a, b, 1'b1);
		@(negedge mclk);
		chk(160'({result.valid, result.destination, result.data, bad_opcode}), 160'({1'b1, i[25:21], exp, 1'b0}));
	endtask : go

	////////////////////////////////////////////////////////////////////////
	// Scenarios
	task t_reset;
		@(negedge mclk);
		chk(160'({result, saturation_flag, bad_opcode}), 160'(0));
	endtask : t_reset

	task t_shift;
		logic [10:0] xo [6] = '{11'h304, 11'h344, 11'h384, 11'h204, 11'h244, 11'h284};
		for (int k = 0; k < 6; k++) begin
			go(ins(xo[k], 5'(k)), SA, SB, shr(SA, SB, 8 << (k % 3), k < 3));
		end
	endtask : t_shift

	task t_octet;
		go(ins(11'h44c, 5'd9), SA, 128'h7f, SA >> 120);
		go(ins(11'h44c, 5'd10), SA, {16{8'h07}}, SA);
		go(ins(11'h2c4, 5'd11), SA, {16{8'h07}}, SA >> 7);
	endtask : t_octet

	// Right half of a funnel shift: octet then bit shift with one count register
	task t_funnel;
		logic [127:0] c;
		c = {16{8'h2b}};
		go(ins(11'h44c, 5'd12), SA, c, SA >> 40);
		go(ins(11'h2c4, 5'd13), SA >> 40, c, SA >> 43);
	endtask : t_funnel

	task t_fp;
		for (int f = 0; f < 2; f++) begin
			@(posedge mclk);
			denormal_flush_mode <= f[0];
			go(ins(11'h04a, 5'd5), FA, FB, f ? FF : FN);
		end
	endtask : t_fp

	task clr_flag;
		@(posedge mclk);
		sat_wr_en <= 1'b1;
		sat_wr_val <= 1'b0;
		@(posedge mclk);
		sat_wr_en <= 1'b0;
		@(negedge mclk);
		chk(160'(saturation_flag), 160'(1'b0));
	endtask : clr_flag

	// Quiet difference first, then one that clamps high at every width and low for bytes only
	task t_sat;
		logic [10:0] xo [3] = '{11'h700, 11'h740, 11'h780};
		for (int k = 0; k < 3; k++) begin
			clr_flag();
			go(ins(xo[k], 5'd3), SN, SM, sats(SN, SM, 8 << k));
			chk(160'(saturation_flag), 160'(1'b0));
			go(ins(xo[k], 5'd4), SC, SD, sats(SC, SD, 8 << k));
			chk(160'(saturation_flag), 160'(1'b1));
		end
	endtask : t_sat

	// Two issues in adjacent cycles; flag must survive non-saturating work
	task t_b2b;
		int n0;
		@(posedge mclk);
		disp.put(ins(11'h204, 5'd7), SA, SB, 1'b0);
		// Taken here so the write-back of the previous scenario is already counted
		n0 = disp.n_writes;
		disp.put(ins(11'h580, 5'd8), SUA, SUB, 1'b1);
		@(negedge mclk);
		chk(160'(result.data), 160'(SUX));
		chk(160'(disp.vrf[7]), 160'(shr(SA, SB, 8, 1'b0)));
		@(negedge mclk);
		chk(160'(disp.vrf[8]), 160'(SUX));
		chk(160'(disp.n_writes - n0), 160'(2));
		chk(160'(saturation_flag), 160'(1'b1));
	endtask : t_b2b

	task t_bad;
		logic [31:0] bad [2] = '{32'h1400_0304, 32'h1000_02c5};
		for (int k = 0; k < 2; k++) begin
			@(posedge mclk);
			disp.put(bad[k], SA, SB, 1'b1);
			@(negedge mclk);
			chk(160'({result.valid, bad_opcode}), 160'(2'b01));
		end
	endtask : t_bad

	////////////////////////////////////////////////////////////////////////
	// Main sequence and watchdog
	initial begin
		mclk = 1'b0;
		rst_n = 1'b0;
		denormal_flush_mode = 1'b0;
		sat_wr_en = 1'b0;
		sat_wr_val = 1'b0;
		fails = 0;
		n_checks = 0;
		repeat (3) @(posedge mclk);
		t_reset();
		@(posedge mclk);
		rst_n <= 1'b1;
		t_shift();
		t_octet();
		t_funnel();
		t_fp();
		t_sat();
		t_b2b();
		t_bad();
		repeat (2) @(posedge mclk);
		tally_and_finish();
	end

	initial begin
		repeat (3000) @(posedge mclk);
		fails++;
		tally_and_finish();
	end
endmodule : tb_top

/* File: sim/vsrsu_disp_model.sv */
// Dispatch and vector register file model facing the datapath
`timescale 1ns/100ps
module vsrsu_disp_model
	import vsrsu_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire vsrsu_res_t result,
	output logic issue_valid,
	output vsrsu_req_t issue
);
	logic [127:0] vrf [32];
	int n_writes;

	initial begin
		issue_valid = 1'b0;
		issue = '0;
		n_writes = 0;
	end

	////////////////////////////////////////////////////////////////////////
	// Write back only on a valid result, whole register at once
	always @(posedge mclk) begin
		if (rst_n === 1'b1 && result.valid === 1'b1) begin
			vrf[result.destination] <= result.data;
			n_writes <= n_writes + 1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Call just after a rising edge; a released bus shows inverted data
	task put(input logic [31:0] ins, input logic [127:0] a, input logic [127:0] b, input bit last);
		issue <= {ins, a, b};
		issue_valid <= 1'b1;
		@(posedge mclk);
		if (last) begin
			issue_valid <= 1'b0;
			issue <= ~{ins, a, b};
		end
	endtask : put
endmodule : vsrsu_disp_model
